// [verilog/mcs_map.svh]
// Register offsets, field positions, reset values and timing counts of the main clock controller
`ifndef MCS_MAP_SVH
`define MCS_MAP_SVH

`define MCS_OFF_SOURCE      8'h00
`define MCS_OFF_PRESCALE    8'h01
`define MCS_OFF_LOCK        8'h02
`define MCS_OFF_STATE       8'h03
`define MCS_OFF_FAST_CTRL   8'h10
`define MCS_OFF_FAST_TRIM_A 8'h11
`define MCS_OFF_FAST_TRIM_B 8'h12
`define MCS_OFF_SLOW_CTRL   8'h18

`define MCS_SRC_FAST        2'h0
`define MCS_SRC_SLOW        2'h1
`define MCS_SRC_RSVD        2'h2
`define MCS_SRC_EXT         2'h3
`define MCS_SOURCE_RESET    2'h0
`define MCS_PRESCALE_RESET  8'h11

`define MCS_BIT_EXT_STARTED 7
`define MCS_BIT_SLOW_STABLE 5
`define MCS_BIT_FAST_STABLE 4
`define MCS_BIT_SWITCH_PEND 0
`define MCS_BIT_KEEP_RUN    1
`define MCS_BIT_CAL_LOCK    7
`define MCS_BIT_FREEZE      0
`define MCS_BIT_PRESCALE_ON 0

`define MCS_OSC_GATE_TICKS  4
`define MCS_EXT_GATE_TICKS  2
`define MCS_GUARD_WINDOW    3'h4

`define MCS_CLK_PERIOD_NS   8
`define MCS_FAST_STARTUP_NS 1000
`define MCS_SLOW_STARTUP_NS 200000
`define MCS_FAST_STARTUP_CYC ((`MCS_FAST_STARTUP_NS + `MCS_CLK_PERIOD_NS - 1) / `MCS_CLK_PERIOD_NS)
`define MCS_SLOW_STARTUP_CYC ((`MCS_SLOW_STARTUP_NS + `MCS_CLK_PERIOD_NS - 1) / `MCS_CLK_PERIOD_NS)

`endif

// [verilog/mcs_pkg.sv]
// Types shared by the main clock controller
package mcs_pkg;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } mcs_bus_s;

   typedef struct packed {
      logic [3:0] slope;
      logic [5:0] trim;
   } mcs_cal_s;

   typedef enum logic [1:0] {
      MCS_RUN    = 2'b01,
      MCS_SWITCH = 2'b10
   } mcs_sw_e;

endpackage : mcs_pkg

// [verilog/mcs_osc_gate.sv]
// Oscillator power, start-up and clock gate model for one clock source
`timescale 1ns/1ns
module mcs_osc_gate #(
   parameter int GATE_TICKS  = 4,
   parameter int STARTUP_CYC = 125
) (
   input  wire logic ref_clk,
   input  wire logic arst_n,
   input  wire logic osc_tick,
   input  wire logic request,
   input  wire logic keep_run,
   output logic      powered,
   output logic      stable,
   output logic      clk_en
);
   localparam int WW = $clog2(STARTUP_CYC + 1);
   localparam int GW = $clog2(GATE_TICKS + 1);

   logic [WW-1:0] warm_r, warm_nxt;
   logic [GW-1:0] gate_r, gate_nxt;
   logic          warm_done;

   // Keep-running holds the oscillator warm so a later request skips the analog start-up
   assign powered   = request | keep_run;
   assign warm_done = (warm_r == WW'(STARTUP_CYC));
   assign stable    = request && (gate_r == GW'(GATE_TICKS));
   assign clk_en    = stable && osc_tick;

   always_comb begin
      warm_nxt = warm_r;
      gate_nxt = gate_r;
      if (!powered) begin
         warm_nxt = '0;
      end else if (!warm_done) begin
         warm_nxt = warm_r + WW'(1);
      end
      if (!request) begin
         gate_nxt = '0;
      end else if (warm_done && osc_tick && gate_r != GW'(GATE_TICKS)) begin
         gate_nxt = gate_r + GW'(1);
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         warm_r <= '0;
         gate_r <= '0;
      end else begin
         warm_r <= warm_nxt;
         gate_r <= gate_nxt;
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!arst_n);

   a_stable_needs_req: assert property (stable |-> request && powered && warm_done)
      else $error("oscillator stable without request");
   a_gate_after_ticks: assert property ($rose(stable) |-> $past(osc_tick) && $past(warm_done))
      else $error("clock gate opened without an oscillator tick after warm-up");

endmodule : mcs_osc_gate

// [verilog/mcs_top.sv]
// Main clock source select, prescaler, lock and oscillator calibration registers
// Functional notes
// - Source code 0 picks fast RC, 1 slow RC, 3 external clock; 2 reserved.
// - Switch pending flag stays set until new source stable and main clock moved.
// - Prescale ratio codes map to dividers 2..64 and 6,10,12,24,48.
// - Ratio may change while running; peripheral clock follows without reset.
// - Prescaler off passes main clock undivided regardless of ratio.
// - Freeze bit blocks writes to source, prescale and current source calibration.
// - Once frozen, lock register is inaccessible until hardware reset.
// - External-started status reads one once the external clock started.
// - Oscillator stable bits read one only while that oscillator is requested.
// - Keep-running bit keeps an oscillator powered in every mode.
// - A kept-running oscillator gives no clock unless requested.
// - Gate opens four oscillator cycles after start-up, two for the external clock; keep-running skips start-up.
// - Six-bit fast trim loads at reset from the frequency-selected factory set.
// - Four-bit temperature slope loads at reset from the selected factory set.
// - Fuse calibration lock bit blocks writes to both fast trim registers.
// - Protected registers change only within four instructions after the unlock key.
`timescale 1ns/1ns
`include "mcs_map.svh"
module mcs_top #(
   parameter int FAST_STARTUP_CYC = `MCS_FAST_STARTUP_CYC,
   parameter int SLOW_STARTUP_CYC = `MCS_SLOW_STARTUP_CYC
) (
   input  wire logic             ref_clk,
   input  wire logic             arst_n,
   input  wire mcs_pkg::mcs_bus_s bus_req,
   output logic [7:0]            rdata,
   input  wire logic             guard_key_written,
   input  wire logic             instr_done,
   input  wire logic             fast_osc_tick,
   input  wire logic             slow_osc_tick,
   input  wire logic             ext_clock_in,
   input  wire logic             periph_req_fast,
   input  wire logic             periph_req_slow,
   input  wire logic             periph_req_ext,
   input  wire logic             standby_sleep,
   input  wire logic             freq_select_fuse,
   input  wire logic             trim_lock_fuse,
   input  wire mcs_pkg::mcs_cal_s fuse_cal_16,
   input  wire mcs_pkg::mcs_cal_s fuse_cal_20,
   output logic                  main_clk_en,
   output logic                  peripheral_clock_en,
   output logic                  fast_osc_power,
   output logic                  slow_osc_power,
   output logic                  fast_osc_out,
   output logic                  slow_osc_out,
   output logic [5:0]            fast_osc_trim,
   output logic [3:0]            fast_osc_temp_slope
);
   import mcs_pkg::*;

   // Register state
   logic [1:0] target_src_r, target_src_nxt;
   logic [1:0] current_src_r, current_src_nxt;
   mcs_sw_e    sw_state_r, sw_state_nxt;
   logic [3:0] prescale_ratio_r, prescale_ratio_nxt;
   logic       prescale_on_r, prescale_on_nxt;
   logic       main_clock_freeze_r, main_clock_freeze_nxt;
   logic       fast_keep_r, fast_keep_nxt;
   logic       slow_keep_r, slow_keep_nxt;
   logic [5:0] fast_osc_trim_r, fast_osc_trim_nxt;
   logic [3:0] fast_osc_temp_slope_r, fast_osc_temp_slope_nxt;
   logic       cal_lock_r, cal_lock_nxt;
   logic       cal_loaded_r, cal_loaded_nxt;
   logic [2:0] guard_cnt_r, guard_cnt_nxt;
   logic       ext_started_r, ext_started_nxt;
   logic [7:0] rdata_r, rdata_nxt;

   // Clock path state
   logic       ext_prev_r;
   logic       main_clk_r, main_clk_nxt;
   logic       periph_clk_r, periph_clk_nxt;
   logic [5:0] div_cnt_r, div_cnt_nxt;
   logic [6:0] act_div_r, act_div_nxt;
   logic       fast_pwr_r, slow_pwr_r, fast_out_r, slow_out_r;

   logic       ext_tick, guard_open, wr_ok, main_req;
   logic       fast_req, slow_req, ext_req;
   logic       fast_stable, slow_stable, ext_stable;
   logic       fast_en, slow_en, ext_en, src_tick, target_stable;
   logic       fast_pwr, slow_pwr;
   logic [1:0] wr_src;
   logic [3:0] wr_ratio;
   mcs_cal_s   fuse_cal;

   // Divider for a ratio code; zero marks a reserved code
   function automatic logic [6:0] ratio_div(input logic [3:0] code);
      case (code)
         4'h0:    ratio_div = 7'h02;
         4'h1:    ratio_div = 7'h04;
         4'h2:    ratio_div = 7'h08;
         4'h3:    ratio_div = 7'h10;
         4'h4:    ratio_div = 7'h20;
         4'h5:    ratio_div = 7'h40;
         4'h8:    ratio_div = 7'h06;
         4'h9:    ratio_div = 7'h0A;
         4'hA:    ratio_div = 7'h0C;
         4'hB:    ratio_div = 7'h18;
         4'hC:    ratio_div = 7'h30;
         default: ratio_div = 7'h00;
      endcase
   endfunction : ratio_div

   assign ext_tick = ext_clock_in && !ext_prev_r;
   // Standby stops the main clock request; only keep-running or peripherals hold an oscillator
   assign main_req = !standby_sleep;
   assign fast_req = periph_req_fast || (main_req && (current_src_r == `MCS_SRC_FAST
                                                   || target_src_r == `MCS_SRC_FAST));
   assign slow_req = periph_req_slow || (main_req && (current_src_r == `MCS_SRC_SLOW
                                                   || target_src_r == `MCS_SRC_SLOW));
   assign ext_req  = periph_req_ext || (main_req && (current_src_r == `MCS_SRC_EXT
                                                  || target_src_r == `MCS_SRC_EXT));

   mcs_osc_gate #(.GATE_TICKS(`MCS_OSC_GATE_TICKS), .STARTUP_CYC(FAST_STARTUP_CYC)) u_fast (
      .ref_clk  (ref_clk),
      .arst_n   (arst_n),
      .osc_tick (fast_osc_tick),
      .request  (fast_req),
      .keep_run (fast_keep_r),
      .powered  (fast_pwr),
      .stable   (fast_stable),
      .clk_en   (fast_en)
   );

   mcs_osc_gate #(.GATE_TICKS(`MCS_OSC_GATE_TICKS), .STARTUP_CYC(SLOW_STARTUP_CYC)) u_slow (
      .ref_clk  (ref_clk),
      .arst_n   (arst_n),
      .osc_tick (slow_osc_tick),
      .request  (slow_req),
      .keep_run (slow_keep_r),
      .powered  (slow_pwr),
      .stable   (slow_stable),
      .clk_en   (slow_en)
   );

   // External pin has no analog start-up, only its gate cycles
   mcs_osc_gate #(.GATE_TICKS(`MCS_EXT_GATE_TICKS), .STARTUP_CYC(1)) u_ext (
      .ref_clk  (ref_clk),
      .arst_n   (arst_n),
      .osc_tick (ext_tick),
      .request  (ext_req),
      .keep_run (1'b0),
      .powered  (),
      .stable   (ext_stable),
      .clk_en   (ext_en)
   );

   always_comb begin
      case (current_src_r)
         `MCS_SRC_FAST: src_tick = fast_en;
         `MCS_SRC_SLOW: src_tick = slow_en;
         `MCS_SRC_EXT:  src_tick = ext_en;
         default:       src_tick = 1'b0;
      endcase
      case (target_src_r)
         `MCS_SRC_FAST: target_stable = fast_stable;
         `MCS_SRC_SLOW: target_stable = slow_stable;
         `MCS_SRC_EXT:  target_stable = ext_stable;
         default:       target_stable = 1'b0;
      endcase
   end

   assign guard_open = (guard_cnt_r != 3'h0);
   assign wr_ok      = bus_req.wr && guard_open;
   assign wr_src     = bus_req.wdata[1:0];
   assign wr_ratio   = bus_req.wdata[4:1];
   assign fuse_cal   = freq_select_fuse ? fuse_cal_20 : fuse_cal_16;

   // Register file and source switch sequencing
   always_comb begin
      target_src_nxt          = target_src_r;
      current_src_nxt         = current_src_r;
      sw_state_nxt            = sw_state_r;
      prescale_ratio_nxt      = prescale_ratio_r;
      prescale_on_nxt         = prescale_on_r;
      main_clock_freeze_nxt   = main_clock_freeze_r;
      fast_keep_nxt           = fast_keep_r;
      slow_keep_nxt           = slow_keep_r;
      fast_osc_trim_nxt       = fast_osc_trim_r;
      fast_osc_temp_slope_nxt = fast_osc_temp_slope_r;
      cal_lock_nxt            = cal_lock_r;
      cal_loaded_nxt          = 1'b1;
      guard_cnt_nxt           = guard_cnt_r;
      ext_started_nxt         = ext_started_r || ext_stable;
      rdata_nxt               = 8'h00;

      if (guard_key_written) begin
         guard_cnt_nxt = `MCS_GUARD_WINDOW;
      end else if (instr_done && guard_open) begin
         guard_cnt_nxt = guard_cnt_r - 3'h1;
      end

      if (!cal_loaded_r) begin
         fast_osc_trim_nxt       = fuse_cal.trim;
         fast_osc_temp_slope_nxt = fuse_cal.slope;
         cal_lock_nxt            = trim_lock_fuse;
      end else if (wr_ok) begin
         case (bus_req.addr)
            `MCS_OFF_SOURCE: begin
               if (!main_clock_freeze_r && wr_src != `MCS_SRC_RSVD) begin
                  target_src_nxt = wr_src;
               end
            end
            `MCS_OFF_PRESCALE: begin
               if (!main_clock_freeze_r) begin
                  prescale_on_nxt = bus_req.wdata[`MCS_BIT_PRESCALE_ON];
                  if (ratio_div(wr_ratio) != 7'h00) begin
                     prescale_ratio_nxt = wr_ratio;
                  end
               end
            end
            `MCS_OFF_LOCK: begin
               if (!main_clock_freeze_r && bus_req.wdata[`MCS_BIT_FREEZE]) begin
                  main_clock_freeze_nxt = 1'b1;
               end
            end
            `MCS_OFF_FAST_CTRL: fast_keep_nxt = bus_req.wdata[`MCS_BIT_KEEP_RUN];
            `MCS_OFF_SLOW_CTRL: slow_keep_nxt = bus_req.wdata[`MCS_BIT_KEEP_RUN];
            `MCS_OFF_FAST_TRIM_A: begin
               if (!cal_lock_r && !(main_clock_freeze_r && current_src_r == `MCS_SRC_FAST)) begin
                  fast_osc_trim_nxt = bus_req.wdata[5:0];
               end
            end
            `MCS_OFF_FAST_TRIM_B: begin
               if (!cal_lock_r && !(main_clock_freeze_r && current_src_r == `MCS_SRC_FAST)) begin
                  fast_osc_temp_slope_nxt = bus_req.wdata[3:0];
               end
            end
            default: ;
         endcase
      end

      case (sw_state_r)
         MCS_RUN: begin
            if (target_src_r != current_src_r) begin
               sw_state_nxt = MCS_SWITCH;
            end
         end
         MCS_SWITCH: begin
            // Moving only while no tick is due keeps the last old pulse whole
            if (target_stable && !src_tick) begin
               current_src_nxt = target_src_r;
               sw_state_nxt    = MCS_RUN;
            end
         end
         default: sw_state_nxt = MCS_RUN;
      endcase
      if (target_src_nxt != current_src_nxt) begin
         sw_state_nxt = MCS_SWITCH;
      end

      if (bus_req.rd) begin
         case (bus_req.addr)
            `MCS_OFF_SOURCE:      rdata_nxt = {6'h00, target_src_r};
            `MCS_OFF_PRESCALE:    rdata_nxt = {3'h0, prescale_ratio_r, prescale_on_r};
            `MCS_OFF_LOCK:        rdata_nxt = 8'h00;
            `MCS_OFF_STATE: begin
               rdata_nxt[`MCS_BIT_SWITCH_PEND] = (sw_state_r == MCS_SWITCH);
               rdata_nxt[`MCS_BIT_EXT_STARTED] = ext_started_r;
               rdata_nxt[`MCS_BIT_SLOW_STABLE] = slow_stable;
               rdata_nxt[`MCS_BIT_FAST_STABLE] = fast_stable;
            end
            `MCS_OFF_FAST_CTRL:   rdata_nxt[`MCS_BIT_KEEP_RUN] = fast_keep_r;
            `MCS_OFF_SLOW_CTRL:   rdata_nxt[`MCS_BIT_KEEP_RUN] = slow_keep_r;
            `MCS_OFF_FAST_TRIM_A: rdata_nxt = {2'h0, fast_osc_trim_r};
            `MCS_OFF_FAST_TRIM_B: rdata_nxt = {cal_lock_r, 3'h0, fast_osc_temp_slope_r};
            default:              rdata_nxt = 8'h00;
         endcase
      end
   end

   // Main and peripheral clock enables
   always_comb begin
      main_clk_nxt   = src_tick;
      periph_clk_nxt = 1'b0;
      div_cnt_nxt    = div_cnt_r;
      act_div_nxt    = act_div_r;
      if (src_tick) begin
         if (!prescale_on_r) begin
            periph_clk_nxt = 1'b1;
            div_cnt_nxt    = 6'h00;
            act_div_nxt    = ratio_div(prescale_ratio_r);
         end else if ({1'b0, div_cnt_r} >= act_div_r - 7'h01) begin
            periph_clk_nxt = 1'b1;
            div_cnt_nxt    = 6'h00;
            act_div_nxt    = ratio_div(prescale_ratio_r);
         end else begin
            div_cnt_nxt = div_cnt_r + 6'h01;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         target_src_r          <= `MCS_SOURCE_RESET;
         current_src_r         <= `MCS_SOURCE_RESET;
         sw_state_r            <= MCS_RUN;
         prescale_ratio_r      <= 4'(`MCS_PRESCALE_RESET >> 1);
         prescale_on_r         <= 1'(`MCS_PRESCALE_RESET & 8'h01);
         main_clock_freeze_r   <= 1'b0;
         fast_keep_r           <= 1'b0;
         slow_keep_r           <= 1'b0;
         fast_osc_trim_r       <= 6'h00;
         fast_osc_temp_slope_r <= 4'h0;
         cal_lock_r            <= 1'b1;
         cal_loaded_r          <= 1'b0;
         guard_cnt_r           <= 3'h0;
         ext_started_r         <= 1'b0;
         rdata_r               <= 8'h00;
         ext_prev_r            <= 1'b0;
         main_clk_r            <= 1'b0;
         periph_clk_r          <= 1'b0;
         div_cnt_r             <= 6'h00;
         // Divider of the reset ratio code, so the first period is already whole
         act_div_r             <= 7'h06;
         fast_pwr_r            <= 1'b0;
         slow_pwr_r            <= 1'b0;
         fast_out_r            <= 1'b0;
         slow_out_r            <= 1'b0;
      end else begin
         target_src_r          <= target_src_nxt;
         current_src_r         <= current_src_nxt;
         sw_state_r            <= sw_state_nxt;
         prescale_ratio_r      <= prescale_ratio_nxt;
         prescale_on_r         <= prescale_on_nxt;
         main_clock_freeze_r   <= main_clock_freeze_nxt;
         fast_keep_r           <= fast_keep_nxt;
         slow_keep_r           <= slow_keep_nxt;
         fast_osc_trim_r       <= fast_osc_trim_nxt;
         fast_osc_temp_slope_r <= fast_osc_temp_slope_nxt;
         cal_lock_r            <= cal_lock_nxt;
         cal_loaded_r          <= cal_loaded_nxt;
         guard_cnt_r           <= guard_cnt_nxt;
         ext_started_r         <= ext_started_nxt;
         rdata_r               <= rdata_nxt;
         ext_prev_r            <= ext_clock_in;
         main_clk_r            <= main_clk_nxt;
         periph_clk_r          <= periph_clk_nxt;
         div_cnt_r             <= div_cnt_nxt;
         act_div_r             <= act_div_nxt;
         fast_pwr_r            <= fast_pwr;
         slow_pwr_r            <= slow_pwr;
         fast_out_r            <= fast_en;
         slow_out_r            <= slow_en;
      end
   end

   assign rdata               = rdata_r;
   assign main_clk_en         = main_clk_r;
   assign peripheral_clock_en = periph_clk_r;
   assign fast_osc_power      = fast_pwr_r;
   assign slow_osc_power      = slow_pwr_r;
   assign fast_osc_out        = fast_out_r;
   assign slow_osc_out        = slow_out_r;
   assign fast_osc_trim       = fast_osc_trim_r;
   assign fast_osc_temp_slope = fast_osc_temp_slope_r;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!arst_n);

   a_rsvd_source_kept: assert property (wr_ok && bus_req.addr == `MCS_OFF_SOURCE && wr_src == `MCS_SRC_RSVD
      && cal_loaded_r |=> $stable(target_src_r))
      else $error("reserved source code changed the selection");
   a_switch_pending: assert property (target_src_r != current_src_r |-> sw_state_r == MCS_SWITCH)
      else $error("source differs but no switch pending");
   a_freeze_sticky: assert property (main_clock_freeze_r |=> main_clock_freeze_r)
      else $error("freeze bit cleared without reset");
   a_frozen_prescale: assert property (main_clock_freeze_r |=> $stable(prescale_ratio_r) && $stable(prescale_on_r))
      else $error("prescaler changed while frozen");
   a_guard_closed: assert property (bus_req.wr && !guard_open && cal_loaded_r
      |=> $stable(target_src_r) && $stable(prescale_ratio_r) && $stable(fast_osc_trim_r))
      else $error("protected register changed outside unlock window");
   a_cal_fuse_lock: assert property (cal_lock_r && cal_loaded_r |=> $stable(fast_osc_trim_r)
      && $stable(fast_osc_temp_slope_r))
      else $error("calibration changed while fuse-locked");
   a_passthrough: assert property (!prescale_on_r && src_tick |=> periph_clk_r && main_clk_r)
      else $error("undivided peripheral clock missed a main pulse");
   a_periph_on_main: assert property (periph_clk_r |-> main_clk_r)
      else $error("peripheral pulse without main pulse");
   a_div2_gap: assert property (prescale_on_r && act_div_r == 7'h02 && src_tick && div_cnt_r == 6'h00
      |=> !periph_clk_r)
      else $error("divide-by-two fired on consecutive main pulses");
   a_ext_started: assert property (ext_stable |=> ext_started_r)
      else $error("external started flag missing");

   c_switch_done: cover property (sw_state_r == MCS_SWITCH ##1 sw_state_r == MCS_RUN);
   c_freeze_set: cover property ($rose(main_clock_freeze_r));
   c_divided_pulse: cover property (prescale_on_r && periph_clk_r);

endmodule : mcs_top

// [bench/tb_mcs_top.sv]
// Self-checking bench for the main clock controller registers and prescaler
`timescale 1ns/1ns
module tb_mcs_top;
   import mcs_pkg::*;
   logic       ref_clk, arst_n, key, instr, ft, st, mce, pce, ext, stby, fsel, tlock, fpw, spw, fo, so;
   logic [5:0] trm;
   logic [3:0] slp;
   logic [1:0] sdiv;
   logic [7:0] rdata, got;
   mcs_bus_s   bus;
   mcs_cal_s   c16, c20;
   int         mismatches, checked, mc, pc, fc, sc;
   localparam logic [3:0] CODE[11] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h8, 4'h9, 4'hA, 4'hB, 4'hC};
   localparam int         DIV[11]  = '{2, 4, 8, 16, 32, 64, 6, 10, 12, 24, 48};
   // Short start-up counts keep the run brief
   mcs_top #(.FAST_STARTUP_CYC(3), .SLOW_STARTUP_CYC(3)) uut (
      .ref_clk(ref_clk), .arst_n(arst_n), .bus_req(bus), .rdata(rdata), .guard_key_written(key),
      .instr_done(instr), .fast_osc_tick(ft), .slow_osc_tick(st), .ext_clock_in(ext),
      .periph_req_fast(1'b0), .periph_req_slow(1'b0), .periph_req_ext(1'b0), .standby_sleep(stby),
      .freq_select_fuse(fsel), .trim_lock_fuse(tlock), .fuse_cal_16(c16), .fuse_cal_20(c20),
      .main_clk_en(mce), .peripheral_clock_en(pce), .fast_osc_power(fpw), .slow_osc_power(spw),
      .fast_osc_out(fo), .slow_osc_out(so), .fast_osc_trim(trm), .fast_osc_temp_slope(slp));
   initial begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end
   // Fast tick every second cycle, slow tick and external rising edge every fourth
   always @(posedge ref_clk) begin
      ft <= ~ft;
      ext <= sdiv[1];
      sdiv <= sdiv + 2'h1;
      st <= (sdiv == 2'h0);
   end
   task automatic stop_test();
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : stop_test
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      checked++;
      if (g !== e) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   // Optional key pulse, then a one-cycle write strobe
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic k);
      @(posedge ref_clk) key <= k;
      @(posedge ref_clk) begin
         key <= 1'b0;
         bus.addr <= a;
         bus.wdata <= d;
         bus.wr <= 1'b1;
      end
      @(posedge ref_clk) bus.wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a);
      @(posedge ref_clk) begin
         bus.addr <= a;
         bus.rd <= 1'b1;
      end
      @(posedge ref_clk) bus.rd <= 1'b0;
      @(negedge ref_clk) got = rdata;
   endtask : rd
   task automatic count(input int n);
      mc = 0;
      pc = 0;
      fc = 0;
      sc = 0;
      repeat (n) @(negedge ref_clk) begin
         mc += int'(mce);
         pc += int'(pce);
         fc += int'(fo);
         sc += int'(so);
      end
   endtask : count
   task automatic t_reset();
      rd(8'h01); chk("prescale", 8'h11, got);
      rd(8'h02); chk("lock", 8'h00, got);
      rd(8'h10); chk("fast_ctrl", 8'h00, got);
      rd(8'h18); chk("slow_ctrl", 8'h00, got);
      rd(8'h11); chk("trim_a", {2'h0, c20.trim}, got);
      rd(8'h12); chk("trim_b", {4'h0, c20.slope}, got);
   endtask : t_reset
   task automatic t_guard();
      @(posedge ref_clk) key <= 1'b1;
      @(posedge ref_clk) key <= 1'b0;
      repeat (4) @(posedge ref_clk) instr <= 1'b1;
      @(posedge ref_clk) instr <= 1'b0;
      wr(8'h01, 8'h03, 1'b0); rd(8'h01); chk("closed", 8'h11, got);
      wr(8'h01, 8'h03, 1'b1); rd(8'h01); chk("open", 8'h03, got);
   endtask : t_guard
   task automatic t_ratio();
      for (int i = 0; i < 11; i++) begin
         wr(8'h01, {3'h0, CODE[i], 1'b1}, 1'b1);
         repeat (140) @(posedge ref_clk);
         count(16 * DIV[i]);
         chk("divide", 8'h01, 8'(pc == 8 && mc == 8 * DIV[i]));
      end
      wr(8'h01, 8'h1B, 1'b1); rd(8'h01); chk("rsvd_ratio", 8'h19, got);
      wr(8'h01, 8'h18, 1'b1); rd(8'h01); chk("ratio_off", 8'h18, got);
      count(200); chk("undivided", 8'h01, 8'(mc == 100 && pc == 100 && fc == 100 && sc == 0));
   endtask : t_ratio
   // Select a source, then wait until the switch has finished
   task automatic sw(input logic [1:0] s, input logic [7:0] e);
      wr(8'h00, {6'h00, s}, 1'b1); rd(8'h03); chk("pending", 8'h01, got & 8'h01);
      for (int i = 0; i < 100 && got[0] !== 1'b0; i++) rd(8'h03);
      chk("state", e, got & 8'hB1);
      rd(8'h00); chk("source", {6'h00, s}, got);
   endtask : sw
   task automatic t_switch();
      wr(8'h00, 8'h02, 1'b1); rd(8'h00); chk("rsvd_src", 8'h00, got);
      sw(2'h1, 8'h20);
      sw(2'h3, 8'h80);
      sw(2'h0, 8'h90);
   endtask : t_switch
   task automatic t_standby();
      wr(8'h18, 8'h02, 1'b1); rd(8'h18); chk("keep_slow", 8'h02, got);
      count(40); chk("keep_idle", 8'h01, 8'(spw === 1'b1 && sc == 0 && mc == 20));
      rd(8'h03); chk("keep_state", 8'h90, got & 8'hB1);
      @(posedge ref_clk) stby <= 1'b1;
      repeat (4) @(posedge ref_clk);
      count(40); chk("standby", 8'h01, 8'(mc == 0 && fc == 0 && fpw === 1'b0 && spw === 1'b1));
      @(posedge ref_clk) stby <= 1'b0;
      repeat (20) @(posedge ref_clk);
      count(40); chk("wake", 8'h01, 8'(mc == 20 && fpw === 1'b1));
   endtask : t_standby
   // Second reset with the other fuse set and the calibration fuse lock
   task automatic t_rst2();
      @(posedge ref_clk) begin
         arst_n <= 1'b0;
         fsel <= 1'b0;
         tlock <= 1'b1;
         c16 <= {4'h3, 6'h0E};
         c20 <= {4'h6, 6'h31};
      end
      repeat (16) @(posedge ref_clk);
      arst_n <= 1'b1;
      repeat (2) @(posedge ref_clk);
      rd(8'h11); chk("trim_a16", {2'h0, c16.trim}, got);
      rd(8'h12); chk("trim_b16", {1'b1, 3'h0, c16.slope}, got);
      wr(8'h11, 8'h00, 1'b1); rd(8'h11); chk("trim_locked", {2'h0, c16.trim}, got);
      chk("trim_out", {2'h0, c16.trim}, {2'h0, trm});
      chk("slope_out", {4'h0, c16.slope}, {4'h0, slp});
      wr(8'h01, 8'h03, 1'b1); rd(8'h01); chk("unfrozen", 8'h03, got);
   endtask : t_rst2
   task automatic t_lock();
      wr(8'h02, 8'h01, 1'b1);
      wr(8'h01, 8'h03, 1'b1); rd(8'h01); chk("frozen_pre", 8'h18, got);
      wr(8'h00, 8'h01, 1'b1); rd(8'h00); chk("frozen_src", 8'h00, got);
      wr(8'h02, 8'h00, 1'b1); rd(8'h02); chk("lock_hidden", 8'h00, got);
   endtask : t_lock
   initial begin
      arst_n = 1'b0;
      {key, instr, ft, st, sdiv, ext, stby, tlock, mismatches, checked} = '0;
      fsel = 1'b1;
      bus = '0;
      c16 = {4'h5, 6'h15};
      c20 = {4'hA, 6'h2B};
      repeat (16) @(posedge ref_clk);
      arst_n <= 1'b1;
      repeat (2) @(posedge ref_clk);
      t_reset();
      t_guard();
      t_ratio();
      t_switch();
      t_standby();
      t_lock();
      t_rst2();
      stop_test();
   end
   // Whole run needs about 6000 cycles
   initial begin
      #400000;
      mismatches++;
      stop_test();
   end
endmodule : tb_mcs_top
